// ===== design/dpc_serial_regs.vh
// Constants of the dual pot serial command decoder
`ifndef DPC_SERIAL_REGS_VH
`define DPC_SERIAL_REGS_VH

// ============================================================
// Identity and timing
// Device identity nibble, arbitrary value
`define DPC_DEVICE_ID      4'hA
// Clock rate in kHz and nonvolatile programming time in ms
`define DPC_CLK_KHZ        250000
`define DPC_TWR_MS         10
// Longest programming time rounded down to whole cycles
`define DPC_TWR_CYCLES     22'h26_25A0

// ============================================================
// Instruction opcodes, bits 7..4 of the instruction byte
`define DPC_OP_RD_WIPER    4'h9
`define DPC_OP_WR_WIPER    4'hA
`define DPC_OP_RD_SLOT     4'hB
`define DPC_OP_WR_SLOT     4'hC
`define DPC_OP_GANG_RECALL 4'h1
`define DPC_OP_GANG_STORE  4'h8
`define DPC_OP_STORE       4'hE
`define DPC_OP_RECALL      4'hD
`define DPC_OP_STEP        4'h2

// ============================================================
// Instruction byte field positions
`define DPC_OP_MSB         7
`define DPC_OP_LSB         4
`define DPC_SLOT_MSB       3
`define DPC_SLOT_LSB       2
`define DPC_POT_BIT        0

// ============================================================
// Reset values and step limits
`define DPC_SYNC_RESET     6'h03
`define DPC_WIPER_MAX      8'hFF
`define DPC_WIPER_MIN      8'h00

`endif

// ===== design/dpc_serial_decoder.v
// Two-wire command decoder for a dual digital potentiometer
`timescale 1ns/1ns
`include "dpc_serial_regs.vh"
// Summary of operation
// - Opcode 1001 returns the selected pot's wiper position, MSB first, after the ack.
// - Opcode 1010 plus one data byte loads the selected wiper, both bytes acked.
// - Opcode 1011 returns the selected slot of the selected pot, MSB first.
// - Opcode 1100 plus one data byte writes the selected nonvolatile slot, both bytes acked.
// - Opcode 0001 copies the selected slot of both pots into both wipers.
// - Opcode 1000 copies both wipers into the selected slot of each pot.
// - Opcode 1110 copies the selected pot's wiper into the selected slot.
// - Opcode 1101 loads the selected pot's wiper from the selected slot.
// - Opcode 0010 enables stepping; each later clock pulse steps once until stop.
// - Nonvolatile programming starts only after the stop condition.
// - A step pulse with data high moves up toward the high end, low moves down.
// - Every nonvolatile change completes within 10 ms of its programming start.
// - At reset each wiper loads from slot zero of its own pot.

module dpc_serial_decoder #(
    parameter [3:0]  DEVICE_ID    = `DPC_DEVICE_ID,
    parameter [21:0] WRITE_CYCLES = `DPC_TWR_CYCLES
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    input  wire       addr_pin_bit3,
    input  wire       addr_pin_bit2,
    input  wire       addr_pin_bit1,
    input  wire       addr_pin_bit0,
    output reg  [7:0] wiper_pos_pot0,
    output reg  [7:0] wiper_pos_pot1,
    output reg        nv_busy
);

    // ============================================================
    // States of the byte decoder
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_INSTR = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_RDATA = 3'h4;
    localparam [2:0] ST_STEP  = 3'h5;
    localparam [2:0] ST_DONE  = 3'h6;

    // ============================================================
    // Pin synchronisers and glitch filter
    reg  [5:0] sync1;
    reg  [5:0] sync2;
    reg  [5:0] sync3;
    reg  [5:0] filt;
    reg  [5:0] filt_d;
    wire [5:0] raw_pins = {addr_pin_bit3, addr_pin_bit2, addr_pin_bit1,
                           addr_pin_bit0, sda_in, scl_in};

    // A bit changes once the second and third stage agree
    always @(posedge clk) begin
        if (reset) begin
            sync1  <= `DPC_SYNC_RESET;
            sync2  <= `DPC_SYNC_RESET;
            sync3  <= `DPC_SYNC_RESET;
            filt   <= `DPC_SYNC_RESET;
            filt_d <= `DPC_SYNC_RESET;
        end else begin
            sync1  <= raw_pins;
            sync2  <= sync1;
            sync3  <= sync2;
            filt   <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
            filt_d <= filt;
        end
    end

    // Bus events seen on the filtered lines
    wire       scl       = filt[0];
    wire       sda       = filt[1];
    wire [3:0] addr_pins = filt[5:2];
    wire       scl_rise  = scl & ~filt_d[0];
    wire       scl_fall  = ~scl & filt_d[0];
    wire       bus_start = scl & filt_d[0] & filt_d[1] & ~sda;
    wire       bus_stop  = scl & filt_d[0] & ~filt_d[1] & sda;

    // Open-drain data pin only ever pulls low
    assign sda_out = 1'b0;

    // ============================================================
    // Decoder registers
    reg  [2:0]  state;
    reg  [3:0]  bit_cnt;
    reg  [7:0]  shreg;
    reg  [7:0]  rd_byte;
    reg         ack_phase;
    reg  [3:0]  cur_op;
    reg  [1:0]  cur_slot;
    reg         cur_pot;
    reg  [1:0]  pend_we;
    reg  [1:0]  pend_slot;
    reg  [7:0]  pend_data0;
    reg  [7:0]  pend_data1;
    reg  [21:0] nv_cnt;
    reg  [7:0]  slot_mem [0:7];

    // Fields of the byte just received
    wire [3:0] in_op   = shreg[`DPC_OP_MSB:`DPC_OP_LSB];
    wire [1:0] in_slot = shreg[`DPC_SLOT_MSB:`DPC_SLOT_LSB];
    wire       in_pot  = shreg[`DPC_POT_BIT];
    wire [7:0] in_wiper = in_pot ? wiper_pos_pot1 : wiper_pos_pot0;
    wire [7:0] in_slot_val = slot_mem[{in_pot, in_slot}];
    wire [7:0] step_wiper = cur_pot ? wiper_pos_pot1 : wiper_pos_pot0;
    wire       byte_done = scl_fall & ~ack_phase & (bit_cnt == 4'h8);
    wire       nv_done   = nv_busy & (nv_cnt == WRITE_CYCLES - 22'h00_0001);

    // Saturating step value for the stepping pot
    reg [7:0] next_step;
    always @* begin
        next_step = step_wiper;
        if (shreg[0]) begin
            if (step_wiper != `DPC_WIPER_MAX)
                next_step = step_wiper + 8'h01;
        end else begin
            if (step_wiper != `DPC_WIPER_MIN)
                next_step = step_wiper - 8'h01;
        end
    end

    // ============================================================
    // Nonvolatile slot array, written at the end of programming
    always @(posedge clk) begin
        if (nv_done && pend_we[0])
            slot_mem[{1'b0, pend_slot}] <= pend_data0;
        if (nv_done && pend_we[1])
            slot_mem[{1'b1, pend_slot}] <= pend_data1;
    end

    // Programming timer, started by stop with work pending
    always @(posedge clk) begin
        if (reset) begin
            nv_busy <= 1'b0;
            nv_cnt  <= 22'h00_0000;
        end else if (nv_done) begin
            nv_busy <= 1'b0;
            nv_cnt  <= 22'h00_0000;
        end else if (nv_busy) begin
            nv_cnt <= nv_cnt + 22'h00_0001;
        end else if (bus_stop && pend_we != 2'b00) begin
            nv_busy <= 1'b1;
        end
    end

    // ============================================================
    // Byte decoder and wiper registers
    always @(posedge clk) begin
        if (reset) begin
            state          <= ST_IDLE;
            bit_cnt        <= 4'h0;
            shreg          <= 8'h00;
            rd_byte        <= 8'h00;
            ack_phase      <= 1'b0;
            sda_oe         <= 1'b0;
            cur_op         <= 4'h0;
            cur_slot       <= 2'b00;
            cur_pot        <= 1'b0;
            pend_we        <= 2'b00;
            pend_slot      <= 2'b00;
            pend_data0     <= 8'h00;
            pend_data1     <= 8'h00;
            wiper_pos_pot0 <= slot_mem[3'h0];
            wiper_pos_pot1 <= slot_mem[3'h4];
        end else begin
            if (nv_done)
                pend_we <= 2'b00;
            if (bus_stop) begin
                state     <= ST_IDLE;
                ack_phase <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (bus_start) begin
                state     <= ST_ADDR;
                bit_cnt   <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe    <= 1'b0;
            end else if (scl_rise && !ack_phase) begin
                // Sample one bit; in stepping mode it is the step direction
                shreg   <= {shreg[6:0], sda};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && ack_phase) begin
                // End of our acknowledge; a read starts driving its MSB
                ack_phase <= 1'b0;
                bit_cnt   <= 4'h0;
                sda_oe    <= (state == ST_RDATA) ? ~rd_byte[7] : 1'b0;
                if (state == ST_RDATA)
                    rd_byte <= {rd_byte[6:0], 1'b0};
            end else if (scl_fall && state == ST_STEP) begin
                // Only a completed pulse steps, so the clock of a stop never does
                bit_cnt <= 4'h0;
                if (cur_pot)
                    wiper_pos_pot1 <= next_step;
                else
                    wiper_pos_pot0 <= next_step;
            end else if (scl_fall && state == ST_RDATA && bit_cnt < 4'h8) begin
                sda_oe  <= ~rd_byte[7];
                rd_byte <= {rd_byte[6:0], 1'b0};
            end else if (byte_done) begin
                case (state)
                    ST_ADDR: begin
                        if (in_op == DEVICE_ID && shreg[3:0] == addr_pins
                            && !nv_busy) begin
                            sda_oe    <= 1'b1;
                            ack_phase <= 1'b1;
                            state     <= ST_INSTR;
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                    ST_INSTR: begin
                        cur_op    <= in_op;
                        cur_slot  <= in_slot;
                        cur_pot   <= in_pot;
                        sda_oe    <= 1'b1;
                        ack_phase <= 1'b1;
                        state     <= ST_DONE;
                        case (in_op)
                            `DPC_OP_RD_WIPER: begin
                                rd_byte <= in_wiper;
                                state   <= ST_RDATA;
                            end
                            `DPC_OP_RD_SLOT: begin
                                rd_byte <= in_slot_val;
                                state   <= ST_RDATA;
                            end
                            `DPC_OP_WR_WIPER: state <= ST_WDATA;
                            `DPC_OP_WR_SLOT:  state <= ST_WDATA;
                            `DPC_OP_STEP:     state <= ST_STEP;
                            `DPC_OP_GANG_RECALL: begin
                                wiper_pos_pot0 <= slot_mem[{1'b0, in_slot}];
                                wiper_pos_pot1 <= slot_mem[{1'b1, in_slot}];
                            end
                            `DPC_OP_GANG_STORE: begin
                                pend_we    <= 2'b11;
                                pend_slot  <= in_slot;
                                pend_data0 <= wiper_pos_pot0;
                                pend_data1 <= wiper_pos_pot1;
                            end
                            `DPC_OP_STORE: begin
                                pend_we   <= in_pot ? 2'b10 : 2'b01;
                                pend_slot <= in_slot;
                                if (in_pot)
                                    pend_data1 <= wiper_pos_pot1;
                                else
                                    pend_data0 <= wiper_pos_pot0;
                            end
                            `DPC_OP_RECALL: begin
                                if (in_pot)
                                    wiper_pos_pot1 <= in_slot_val;
                                else
                                    wiper_pos_pot0 <= in_slot_val;
                            end
                            default: begin
                                // Unknown opcode: stay off the bus
                                sda_oe    <= 1'b0;
                                ack_phase <= 1'b0;
                            end
                        endcase
                    end
                    ST_WDATA: begin
                        sda_oe    <= 1'b1;
                        ack_phase <= 1'b1;
                        state     <= ST_DONE;
                        if (cur_op == `DPC_OP_WR_WIPER) begin
                            if (cur_pot)
                                wiper_pos_pot1 <= shreg;
                            else
                                wiper_pos_pot0 <= shreg;
                        end else begin
                            pend_we   <= cur_pot ? 2'b10 : 2'b01;
                            pend_slot <= cur_slot;
                            if (cur_pot)
                                pend_data1 <= shreg;
                            else
                                pend_data0 <= shreg;
                        end
                    end
                    ST_RDATA: begin
                        sda_oe <= 1'b0;  // Release for the host's ack bit
                        state  <= ST_DONE;
                    end
                    default: begin
                        // Idle, stepping and finished frames ignore whole bytes
                        bit_cnt <= 4'h0;
                    end
                endcase
            end
        end
    end

endmodule // dpc_serial_decoder

// ===== bench/dpc_decoder_properties.sv
// Pin-level assertions for the dual pot command decoder
`timescale 1ns/1ns
module dpc_decoder_props #(
    parameter [21:0] WRITE_CYCLES = 22'h32
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       addr_pin_bit3,
    input wire logic       addr_pin_bit2,
    input wire logic       addr_pin_bit1,
    input wire logic       addr_pin_bit0,
    input wire logic [7:0] wiper_pos_pot0,
    input wire logic [7:0] wiper_pos_pot1,
    input wire logic       nv_busy
);
    // ============================================================
    // Helper logic
    // Counts cycles of the current programming window
    logic [21:0] busy_len;
    always @(posedge clk) begin
        if (reset || !nv_busy) begin
            busy_len <= 22'h0;
        end else begin
            busy_len <= busy_len + 22'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // An ack or data low holds well past the filter delay
    sequence pull_held;
        sda_oe [*8];
    endsequence
    // ============================================================
    // Assertions
    a_reset_quiet: assert property (disable iff (1'b0) reset |=> !sda_oe && !nv_busy)
        else $error("outputs active after reset");
    a_pull_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("device pulled data while clock high");
    a_release_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("device released data while clock high");
    a_pull_holds: assert property ($rose(sda_oe) |-> pull_held)
        else $error("data pull too short");
    a_busy_no_ack: assert property (nv_busy |-> !$rose(sda_oe))
        else $error("device answered while programming");
    a_prog_after_stop: assert property ($rose(nv_busy) |-> scl_in && sda_in && !$past(sda_in, 8))
        else $error("programming began without stop");
    a_busy_bound: assert property (nv_busy |-> busy_len <= WRITE_CYCLES)
        else $error("programming window too long");
    a_busy_length: assert property ($fell(nv_busy) |-> busy_len + 22'h1 >= WRITE_CYCLES)
        else $error("programming window too short");
endmodule // dpc_decoder_props

// ===== bench/dpc_host_model.sv
// Two-wire bus host model that frames commands for the decoder
`timescale 1ns/1ns
module dpc_host_model (
    input  wire logic clk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_drv
);
    // Idle bus: both lines released, clock stands still
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Waits core cycles, then steps off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One bus clock of 40 core cycles; samples mid high phase
    task automatic xfer_bit(input logic b, output logic r);
        sda_drv = b;
        tick(10);
        scl = 1'b1;
        tick(10);
        r = sda_w;
        tick(10);
        scl = 1'b0;
        tick(10);
    endtask
    // Start: data falls while clock high
    task automatic start();
        tick(10);
        sda_drv = 1'b0;
        tick(10);
        scl = 1'b0;
        tick(10);
    endtask
    // Stop: data rises while clock high
    task automatic stop();
        sda_drv = 1'b0;
        tick(10);
        scl = 1'b1;
        tick(10);
        sda_drv = 1'b1;
        tick(20);
    endtask
    // Byte out MSB first, then the ninth clock returns the ack level
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
        xfer_bit(1'b1, ack);
    endtask
    // Byte in MSB first, then a nack
    task automatic get_byte(output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, v[i]);
        xfer_bit(1'b1, r);
    endtask
endmodule // dpc_host_model

// ===== bench/dpc_serial_decoder_bench.sv
// Self-checking bench for the dual pot serial command decoder
`timescale 1ns/1ns
`include "dpc_serial_regs.vh"
module dpc_serial_decoder_bench;
    // Window outlasts the address byte of the frame sent straight after a store
    localparam [21:0] WRITE_CYCLES = 22'h0200;
    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] instr, data, exp0, exp1;
    } dpc_row_t;
    logic clk = 1'b0, reset = 1'b1, sda_oe, sda_out, nv_busy, ack, scl, sda_drv;
    logic [3:0] straps = 4'h6;
    logic [7:0] wiper0, wiper1, rd;
    int err_total = 0, check_count = 0;
    // Open drain data line with pull-up
    wire sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);
    wire [7:0] addr = {`DPC_DEVICE_ID, straps};
    // Kind 0 two-byte, 1 with data byte, 2 read back into data
    dpc_row_t rows [14] = '{
        '{2'd1, 8'ha0, 8'h5a, 8'h5a, 8'hxx}, '{2'd1, 8'ha1, 8'hc3, 8'h5a, 8'hc3},
        '{2'd1, 8'hc4, 8'h11, 8'h5a, 8'hc3}, '{2'd1, 8'hc1, 8'h22, 8'h5a, 8'hc3},
        '{2'd0, 8'he0, 8'h00, 8'h5a, 8'hc3}, '{2'd0, 8'h88, 8'h00, 8'h5a, 8'hc3},
        '{2'd1, 8'ha0, 8'h00, 8'h00, 8'hc3}, '{2'd1, 8'ha1, 8'hff, 8'h00, 8'hff},
        '{2'd0, 8'h10, 8'h00, 8'h5a, 8'h22}, '{2'd0, 8'hd9, 8'h00, 8'h5a, 8'hc3},
        '{2'd2, 8'h90, 8'h5a, 8'h5a, 8'hc3}, '{2'd2, 8'hb4, 8'h11, 8'h5a, 8'hc3},
        '{2'd2, 8'hb8, 8'h5a, 8'h5a, 8'hc3}, '{2'd1, 8'ha0, 8'hfe, 8'hfe, 8'hc3}};
    always #2 clk = ~clk;
    dpc_host_model i_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_drv(sda_drv));
    dpc_serial_decoder #(.WRITE_CYCLES(WRITE_CYCLES)) i_dut (.clk(clk), .reset(reset),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_pin_bit3(straps[3]), .addr_pin_bit2(straps[2]), .addr_pin_bit1(straps[1]),
        .addr_pin_bit0(straps[0]), .wiper_pos_pot0(wiper0), .wiper_pos_pot1(wiper1),
        .nv_busy(nv_busy));
    // Compares one value and counts it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
            err_total++;
        end
    endtask
    // Bounded wait for the programming window to close
    task automatic wait_ready();
        for (int n = 0; n < 1000 && nv_busy !== 1'b0; n++) i_host.tick(1);
        chk({7'h0, nv_busy}, 8'h00, "programming window");
    endtask
    // Addressed frame with instruction, optional data or read
    task automatic run_cmd(input dpc_row_t r);
        i_host.start();
        i_host.put_byte(addr, ack);
        chk({7'h0, ack}, 8'h00, "address ack");
        i_host.put_byte(r.instr, ack);
        chk({7'h0, ack}, 8'h00, "instruction ack");
        if (r.kind == 2'd1) i_host.put_byte(r.data, ack);
        if (r.kind == 2'd1) chk({7'h0, ack}, 8'h00, "data ack");
        if (r.kind == 2'd2) i_host.get_byte(rd);
        if (r.kind == 2'd2) chk(rd, r.data, "read data");
        i_host.stop();
        wait_ready();
    endtask
    // Prints counts and the verdict
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
    // ============================================================
    // Main sequence
    initial begin
        i_host.tick(8);
        reset = 1'b0;
        i_host.tick(6);
        chk({6'h0, sda_oe, nv_busy}, 8'h00, "reset outputs");
        foreach (rows[i]) begin
            run_cmd(rows[i]);
            chk(wiper0, rows[i].exp0, "wiper pot 0");
            chk(wiper1, rows[i].exp1, "wiper pot 1");
        end
        $display("table rows done");
        // Step up past the top end, then down
        i_host.start();
        i_host.put_byte(addr, ack);
        i_host.put_byte(8'h20, ack);
        foreach (rows[i]) if (i < 5) i_host.xfer_bit(i < 2, rd[0]);
        i_host.stop();
        chk(wiper0, 8'hfc, "stepped wiper");
        chk(wiper1, 8'hc3, "other wiper");
        $display("step test done");
        // Foreign address is ignored
        i_host.start();
        i_host.put_byte({`DPC_DEVICE_ID, ~straps}, ack);
        chk({7'h0, ack}, 8'h01, "foreign address");
        i_host.stop();
        $display("address test done");
        // Slot write, refused frame while busy, then reload at reset
        i_host.start();
        i_host.put_byte(addr, ack);
        i_host.put_byte(8'hc0, ack);
        i_host.put_byte(8'h33, ack);
        i_host.stop();
        i_host.start();
        i_host.put_byte(addr, ack);
        chk({7'h0, ack}, 8'h01, "busy refusal");
        i_host.stop();
        wait_ready();
        chk({7'h0, nv_busy}, 8'h00, "programming done");
        reset = 1'b1;
        i_host.tick(8);
        reset = 1'b0;
        i_host.tick(6);
        chk(wiper0, 8'h33, "reload pot 0");
        chk(wiper1, 8'h22, "reload pot 1");
        $display("reload test done");
        close_out();
    end
endmodule // dpc_serial_decoder_bench
bind dpc_serial_decoder dpc_decoder_props #(.WRITE_CYCLES(WRITE_CYCLES)) i_props (
    .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pin_bit3(addr_pin_bit3), .addr_pin_bit2(addr_pin_bit2),
    .addr_pin_bit1(addr_pin_bit1), .addr_pin_bit0(addr_pin_bit0),
    .wiper_pos_pot0(wiper_pos_pot0), .wiper_pos_pot1(wiper_pos_pot1), .nv_busy(nv_busy));
